/* File: logic/crd_defs.svh */
`ifndef CRD_DEFS_SVH
`define CRD_DEFS_SVH

// Register indices; byte address is four times the index
`define CRD_IDX_BIT_FRAMING 8'h58
`define CRD_IDX_EOF_PATTERN 8'h59
`define CRD_IDX_START_HIGH 8'h5A
`define CRD_IDX_START_LOW 8'h5B
`define CRD_IDX_SYNC_MODE 8'h5C
`define CRD_IDX_CONTROL 8'h60
`define CRD_IDX_STATUS 8'h61
`define CRD_IDX_IRQ_STATUS 8'h62
`define CRD_IDX_IRQ_MASK 8'h63
`define CRD_IDX_RX_DATA 8'h64
`define CRD_IDX_BYTE_COUNT 8'h65

// Field positions of the bit framing register
`define CRD_BF_HALT_ON_BAD_PARITY 5
`define CRD_BF_HALT_ON_FRAME_LENGTH 4
`define CRD_BF_HIGH_BIT_LEADING 3
`define CRD_BF_TERMINATOR_BIT_CHECK 2
`define CRD_BF_ODD_PARITY_SELECT 1
`define CRD_BF_WRITE_MASK 8'h3E

// Sync mode: valid bit count in bits 7 to 4
`define CRD_SM_LEN_HI 7
`define CRD_SM_LEN_LO 4

// Control register bits
`define CRD_CT_START 0
`define CRD_CT_ABORT 1
`define CRD_CT_PARITY_ENABLE 2

// Status register bits
`define CRD_ST_BUSY 0

// Interrupt bits
`define CRD_IRQ_FRAME_DONE 0
`define CRD_IRQ_FRAME_ERROR 1
`define CRD_IRQ_PARITY_ERROR 2
`define CRD_IRQ_BYTE_RECEIVED 3
`define CRD_IRQ_WIDTH 4

// End-of-frame tuple codes
`define CRD_EOF_NONE 2'h0
`define CRD_EOF_ZERO 2'h1
`define CRD_EOF_ONE 2'h2
`define CRD_EOF_COLL 2'h3

// Reset values
`define CRD_RST_BYTE 8'h00
`define CRD_RST_CONTROL 8'h04

// Misc counts
`define CRD_LAST_BIT 3'h7
`define CRD_TERMINATOR_VALUE 1'b1

`endif

/* File: logic/crd_pkg.sv */
package crd_pkg;

  typedef enum logic [4:0] {
    CRD_IDLE = 5'b00001,
    CRD_HUNT = 5'b00010,
    CRD_DATA = 5'b00100,
    CRD_PAR = 5'b01000,
    CRD_STOP = 5'b10000
  } crd_state_e;

  // Configuration frozen at the start of each reception
  typedef struct packed {
    logic halt_on_bad_parity;
    logic halt_on_frame_length;
    logic high_bit_leading;
    logic terminator_bit_check;
    logic odd_parity_select;
    logic parity_enable;
    logic [7:0] end_of_frame_pattern;
    logic [15:0] start_pattern;
    logic [3:0] start_pattern_valid_bits;
  } crd_cfg_s;

  // One demodulated bit
  typedef struct packed {
    logic valid;
    logic value;
    logic coll;
  } crd_bit_s;

endpackage : crd_pkg

/* File: logic/crd_rx_deframer.sv */
`timescale 1ns/1ps
`include "crd_defs.svh"
// Summary of operation
// - With halt_on_bad_parity set, an inverted parity bit ends the reception.
// - With halt_on_frame_length set, reception ends when byte count reaches length.
// - The frame length is the first data byte of the frame.
// - high_bit_leading set assembles bytes MSB first, otherwise LSB first.
// - terminator_bit_check expects, checks and strips a stop bit per character.
// - Each correct stop bit pulses a resynchronise strobe to the demodulator.
// - A wrong stop bit sets the frame error flag and aborts reception.
// - The correct stop bit value is always one.
// - odd_parity_select clear checks even parity, set checks odd parity.
// - End-of-frame pattern holds up to four 2-bit tuples, first at bits 1:0.
// - Tuple codes: 0 none, 1 zero, 2 one, 3 collision.
// - A 00 tuple ends the symbol; higher tuples are ignored.
// - The leftmost active tuple is the symbol bit expected first.
// - Bits 1:0 both zero disable end-of-frame detection.
// - A start pattern, high byte and low byte registers, precedes the data.
// - Sync mode bits 7:4 give how many start pattern bits are valid.
module crd_rx_deframer
  import crd_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic DEMOD_BIT_VALID,
  input wire logic DEMOD_BIT,
  input wire logic DEMOD_COLL,
  output logic DEMOD_RESYNC,
  output logic [7:0] COPRO_DATA,
  output logic COPRO_VALID,
  output logic FRAME_END,
  output logic IRQ
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  // Word index of an address, with a flag for a legal word-aligned access
  function automatic logic [8:0] crd_index(input logic [11:0] addr);
    crd_index = {(addr[1:0] == 2'h0 && addr[11:10] == 2'h0), addr[9:2]};
  endfunction : crd_index
  // Number of active end-of-frame tuples, stopping at the first 00
  function automatic logic [2:0] crd_eof_len(input logic [7:0] pat);
    logic stop;
    stop = 1'b0;
    crd_eof_len = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (!stop && pat[2*i +: 2] != `CRD_EOF_NONE) begin
        crd_eof_len = crd_eof_len + 3'h1;
      end else begin
        stop = 1'b1;
      end
    end
  endfunction : crd_eof_len

  ////////////////////////////////////////////////////////////////////////////
  // APB slave and registers
  logic [7:0] bit_framing;
  logic [7:0] eof_pattern;
  logic [7:0] start_high;
  logic [7:0] start_low;
  logic [7:0] sync_mode;
  logic [7:0] control;
  logic [`CRD_IRQ_WIDTH-1:0] irq_status;
  logic [`CRD_IRQ_WIDTH-1:0] irq_mask;
  logic [`CRD_IRQ_WIDTH-1:0] irq_event;
  logic [7:0] rx_data;
  logic [7:0] byte_cnt;
  logic [8:0] acc_idx;
  logic wr_now;
  logic start_cmd;
  logic abort_cmd;
  crd_state_e state;
  crd_state_e next_state;
  logic [7:0] rd_val;
  logic rd_ok;
  assign acc_idx = crd_index(PADDR);
  assign wr_now = PSEL && PENABLE && PREADY && PWRITE && acc_idx[8];
  assign start_cmd = wr_now && acc_idx[7:0] == `CRD_IDX_CONTROL && PWDATA[`CRD_CT_START];
  assign abort_cmd = wr_now && acc_idx[7:0] == `CRD_IDX_CONTROL && PWDATA[`CRD_CT_ABORT];
  always_comb begin
    rd_ok = acc_idx[8];
    rd_val = `CRD_RST_BYTE;
    case (acc_idx[7:0])
      `CRD_IDX_BIT_FRAMING: rd_val = bit_framing;
      `CRD_IDX_EOF_PATTERN: rd_val = eof_pattern;
      `CRD_IDX_START_HIGH: rd_val = start_high;
      `CRD_IDX_START_LOW: rd_val = start_low;
      `CRD_IDX_SYNC_MODE: rd_val = sync_mode;
      `CRD_IDX_CONTROL: rd_val = control;
      `CRD_IDX_STATUS: rd_val = {7'h00, state != CRD_IDLE};
      `CRD_IDX_IRQ_STATUS: rd_val = {4'h0, irq_status};
      `CRD_IDX_IRQ_MASK: rd_val = {4'h0, irq_mask};
      `CRD_IDX_RX_DATA: rd_val = rx_data;
      `CRD_IDX_BYTE_COUNT: rd_val = byte_cnt;
      default: rd_ok = 1'b0;
    endcase
  end
  // One wait state: ready rises in the second access cycle
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else if (PSEL && PENABLE && !PREADY) begin
      PREADY <= 1'b1;
      PSLVERR <= !rd_ok;
      PRDATA <= (rd_ok && !PWRITE) ? {24'h000000, rd_val} : 32'h00000000;
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      bit_framing <= `CRD_RST_BYTE;
      eof_pattern <= `CRD_RST_BYTE;
      start_high <= `CRD_RST_BYTE;
      start_low <= `CRD_RST_BYTE;
      sync_mode <= `CRD_RST_BYTE;
      control <= `CRD_RST_CONTROL;
      irq_mask <= '0;
    end else if (wr_now && !PSLVERR) begin
      case (acc_idx[7:0])
        `CRD_IDX_BIT_FRAMING: bit_framing <= PWDATA[7:0] & `CRD_BF_WRITE_MASK;
        `CRD_IDX_EOF_PATTERN: eof_pattern <= PWDATA[7:0];
        `CRD_IDX_START_HIGH: start_high <= PWDATA[7:0];
        `CRD_IDX_START_LOW: start_low <= PWDATA[7:0];
        `CRD_IDX_SYNC_MODE: sync_mode <= PWDATA[7:0];
        // Start and abort are strobes and never read back
        `CRD_IDX_CONTROL: control <= {5'h00, PWDATA[`CRD_CT_PARITY_ENABLE], 2'h0};
        `CRD_IDX_IRQ_MASK: irq_mask <= PWDATA[`CRD_IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
  end
  // Sticky status: a new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~((wr_now && acc_idx[7:0] == `CRD_IDX_IRQ_STATUS) ?
                    PWDATA[`CRD_IRQ_WIDTH-1:0] : '0)) | irq_event;
      IRQ <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration snapshot
  crd_cfg_s cfg;
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '0;
    end else if (state == CRD_IDLE && start_cmd) begin
      // Bit framing fields sit in the same order as the first five members
      cfg <= {bit_framing[`CRD_BF_HALT_ON_BAD_PARITY:`CRD_BF_ODD_PARITY_SELECT],
              control[`CRD_CT_PARITY_ENABLE], eof_pattern, start_high, start_low,
              sync_mode[`CRD_SM_LEN_HI:`CRD_SM_LEN_LO]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start and end pattern matching
  crd_bit_s rx_bit;
  logic [15:0] sof_shift;
  logic [15:0] next_sof_shift;
  logic [15:0] sof_mask;
  logic [4:0] sof_cnt;
  logic sof_hit;
  logic [1:0] sym_code;
  logic [7:0] eof_hist;
  logic [7:0] next_eof_hist;
  logic [7:0] eof_mask;
  logic [2:0] eof_len;
  logic [2:0] eof_cnt;
  logic eof_hit;
  assign rx_bit = '{valid: DEMOD_BIT_VALID, value: DEMOD_BIT, coll: DEMOD_COLL};
  assign next_sof_shift = {sof_shift[14:0], rx_bit.value};
  assign sof_mask = 16'hFFFF >> (5'h10 - {1'b0, cfg.start_pattern_valid_bits});
  // Last received bit lines up with bit 0 of the low byte
  assign sof_hit = ({1'b0, sof_cnt} + 6'h1 >= {2'h0, cfg.start_pattern_valid_bits}) &&
                   ((next_sof_shift ^ cfg.start_pattern) & sof_mask) == 16'h0000;
  assign sym_code = rx_bit.coll ? `CRD_EOF_COLL : (rx_bit.value ? `CRD_EOF_ONE : `CRD_EOF_ZERO);
  assign next_eof_hist = {eof_hist[5:0], sym_code};
  assign eof_len = crd_eof_len(cfg.end_of_frame_pattern);
  assign eof_mask = 8'hFF >> (4'h8 - {eof_len, 1'b0});
  // Oldest symbol sits in the highest active tuple, so it is expected first;
  // the count is widened so a saturated count cannot wrap to zero
  assign eof_hit = (cfg.end_of_frame_pattern[1:0] != `CRD_EOF_NONE) &&
                   ({1'b0, eof_cnt} + 4'h1 >= {1'b0, eof_len}) &&
                   ((next_eof_hist ^ cfg.end_of_frame_pattern) & eof_mask) == 8'h00;
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sof_shift <= 16'h0000;
      sof_cnt <= 5'h00;
      eof_hist <= 8'h00;
      eof_cnt <= 3'h0;
    end else if (state == CRD_IDLE) begin
      sof_shift <= 16'h0000;
      sof_cnt <= 5'h00;
      eof_hist <= 8'h00;
      eof_cnt <= 3'h0;
    end else if (rx_bit.valid) begin
      if (state == CRD_HUNT) begin
        sof_shift <= next_sof_shift;
        sof_cnt <= (sof_cnt == 5'h1F) ? sof_cnt : sof_cnt + 5'h01;
      end else begin
        eof_hist <= next_eof_hist;
        eof_cnt <= (eof_cnt == 3'h7) ? eof_cnt : eof_cnt + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character assembly and frame control
  logic [7:0] shift_byte;
  logic [7:0] next_byte;
  logic [2:0] bit_cnt;
  logic [7:0] frame_len;
  logic [7:0] char_val;
  logic [8:0] next_cnt;
  logic deliver;
  logic finish;
  logic frame_err;
  logic parity_err;
  logic resync;
  logic parity_bad;
  always_comb begin
    next_byte = shift_byte;
    if (cfg.high_bit_leading) begin
      next_byte[`CRD_LAST_BIT - bit_cnt] = rx_bit.value;
    end else begin
      next_byte[bit_cnt] = rx_bit.value;
    end
  end
  // Even parity bit equals the XOR of the data; odd parity inverts it
  assign parity_bad = rx_bit.value != (^shift_byte ^ cfg.odd_parity_select);
  assign char_val = (state == CRD_DATA) ? next_byte : shift_byte;
  assign next_cnt = {1'b0, byte_cnt} + 9'h001;
  always_comb begin
    next_state = state;
    deliver = 1'b0;
    finish = 1'b0;
    frame_err = 1'b0;
    parity_err = 1'b0;
    resync = 1'b0;
    case (state)
      CRD_IDLE: begin
        if (start_cmd) begin
          next_state = (sync_mode[`CRD_SM_LEN_HI:`CRD_SM_LEN_LO] == 4'h0) ? CRD_DATA : CRD_HUNT;
        end
      end
      CRD_HUNT: begin
        if (rx_bit.valid && sof_hit) begin
          next_state = CRD_DATA;
        end
      end
      CRD_DATA: begin
        if (rx_bit.valid) begin
          if (eof_hit) begin
            finish = 1'b1;
          end else if (bit_cnt == `CRD_LAST_BIT) begin
            if (cfg.parity_enable) begin
              next_state = CRD_PAR;
            end else if (cfg.terminator_bit_check) begin
              next_state = CRD_STOP;
            end else begin
              deliver = 1'b1;
            end
          end
        end
      end
      CRD_PAR: begin
        if (rx_bit.valid) begin
          if (eof_hit) begin
            finish = 1'b1;
          end else if (parity_bad && cfg.halt_on_bad_parity) begin
            parity_err = 1'b1;
            finish = 1'b1;
          end else begin
            parity_err = parity_bad;
            if (cfg.terminator_bit_check) begin
              next_state = CRD_STOP;
            end else begin
              next_state = CRD_DATA;
              deliver = 1'b1;
            end
          end
        end
      end
      CRD_STOP: begin
        if (rx_bit.valid) begin
          if (eof_hit) begin
            finish = 1'b1;
          end else if (rx_bit.value == `CRD_TERMINATOR_VALUE) begin
            resync = 1'b1;
            deliver = 1'b1;
            next_state = CRD_DATA;
          end else begin
            frame_err = 1'b1;
            finish = 1'b1;
          end
        end
      end
      default: next_state = CRD_IDLE;
    endcase
    // Length limit counts the length byte itself
    if (deliver && cfg.halt_on_frame_length &&
        next_cnt >= {1'b0, (byte_cnt == 8'h00) ? char_val : frame_len}) begin
      finish = 1'b1;
    end
    if (abort_cmd && state != CRD_IDLE) begin
      finish = 1'b1;
    end
    if (finish) begin
      next_state = CRD_IDLE;
    end
  end
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= CRD_IDLE;
      shift_byte <= 8'h00;
      bit_cnt <= 3'h0;
    end else begin
      state <= next_state;
      if (state == CRD_IDLE || deliver) begin
        shift_byte <= 8'h00;
        bit_cnt <= 3'h0;
      end else if (state == CRD_DATA && rx_bit.valid) begin
        shift_byte <= next_byte;
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end
  // Byte counter and length survive the frame end; software can read the byte counter
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt <= 8'h00;
      frame_len <= 8'h00;
      rx_data <= 8'h00;
    end else if (state == CRD_IDLE && start_cmd) begin
      byte_cnt <= 8'h00;
      frame_len <= 8'h00;
    end else if (deliver) begin
      byte_cnt <= next_cnt[7:0];
      rx_data <= char_val;
      if (byte_cnt == 8'h00) begin
        frame_len <= char_val;
      end
    end
  end
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      COPRO_DATA <= 8'h00;
      COPRO_VALID <= 1'b0;
      DEMOD_RESYNC <= 1'b0;
      FRAME_END <= 1'b0;
      irq_event <= '0;
    end else begin
      COPRO_VALID <= deliver;
      if (deliver) begin
        COPRO_DATA <= char_val;
      end
      DEMOD_RESYNC <= resync;
      FRAME_END <= finish;
      irq_event[`CRD_IRQ_FRAME_DONE] <= finish;
      irq_event[`CRD_IRQ_FRAME_ERROR] <= frame_err;
      irq_event[`CRD_IRQ_PARITY_ERROR] <= parity_err;
      irq_event[`CRD_IRQ_BYTE_RECEIVED] <= deliver;
    end
  end
endmodule : crd_rx_deframer

/* File: sim/crd_rx_deframer_asserts.sv */
`timescale 1ns/1ps
module crd_rx_deframer_asserts (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic DEMOD_BIT_VALID,
  input wire logic DEMOD_BIT,
  input wire logic DEMOD_COLL,
  input wire logic DEMOD_RESYNC,
  input wire logic [7:0] COPRO_DATA,
  input wire logic COPRO_VALID,
  input wire logic FRAME_END,
  input wire logic IRQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////
  one_wait_a: assert property ($rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
    else $error("ready not after exactly one wait state");
  ready_pulse_a: assert property (PREADY |-> PSEL && PENABLE ##1 !PREADY)
    else $error("ready outside access or longer than one cycle");
  err_with_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("slave error without ready");
  misalign_err_a: assert property (PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("misaligned access not refused");
  read_clean_a: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0
    && (!PSLVERR || PRDATA[7:0] == 8'h00)) else $error("read data upper bits set");
  byte_after_bit_a: assert property (COPRO_VALID |-> $past(DEMOD_BIT_VALID))
    else $error("byte delivered without a bit taken");
  resync_on_one_a: assert property (DEMOD_RESYNC |-> $past(DEMOD_BIT_VALID)
    && $past(DEMOD_BIT)) else $error("resync without a one stop bit");
  end_cause_a: assert property (FRAME_END |-> $past(DEMOD_BIT_VALID)
    || $past(PREADY) || $past(PREADY, 2)) else $error("frame end without cause");
  end_quiet_a: assert property (FRAME_END |=> !FRAME_END && !COPRO_VALID
    && !DEMOD_RESYNC) else $error("activity after frame end");
  ////////////////////////////////////////////////////////////////////////////
  byte_c: cover property (COPRO_VALID);
  resync_c: cover property (DEMOD_RESYNC);
  end_c: cover property (FRAME_END);
  refuse_c: cover property (PSLVERR);
endmodule : crd_rx_deframer_asserts

/* File: sim/crd_demod_model.sv */
`timescale 1ns/1ps
module crd_demod_model (
  input wire logic REF_CLK,
  output logic DEMOD_BIT_VALID,
  output logic DEMOD_BIT,
  output logic DEMOD_COLL
);
  logic slow;
  initial begin
    DEMOD_BIT_VALID = 1'b0;
    DEMOD_BIT = 1'b0;
    DEMOD_COLL = 1'b0;
    slow = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Code 1 zero, 2 one, 3 collision; the line toggles between bits so a
  // stale value is never mistaken for data
  task send_sym(input logic [1:0] code);
    repeat (slow ? 3 : 0) begin
      @(posedge REF_CLK);
      DEMOD_BIT <= ~DEMOD_BIT;
    end
    @(posedge REF_CLK);
    DEMOD_BIT_VALID <= 1'b1;
    DEMOD_BIT <= code[1];
    DEMOD_COLL <= &code;
    @(posedge REF_CLK);
    DEMOD_BIT_VALID <= 1'b0;
    DEMOD_BIT <= ~code[1];
    DEMOD_COLL <= 1'b0;
  endtask : send_sym
  // Parity and stop codes of 0 mean the bit is left out
  task send_char(input logic [7:0] b, input logic msb, input logic [1:0] par,
                 input logic [1:0] stp);
    for (int i = 0; i < 8; i++) begin
      send_sym(b[msb ? 7 - i : i] ? 2'h2 : 2'h1);
    end
    if (par != 2'h0) begin
      send_sym(par);
    end
    if (stp != 2'h0) begin
      send_sym(stp);
    end
  endtask : send_char
endmodule : crd_demod_model

/* File: sim/crd_rx_deframer_test.sv */
`timescale 1ns/1ps
`include "crd_defs.svh"
module crd_rx_deframer_test;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, DEMOD_BIT_VALID, DEMOD_BIT, DEMOD_COLL, DEMOD_RESYNC;
  logic [7:0] COPRO_DATA;
  logic COPRO_VALID, FRAME_END, IRQ;
  int mismatches = 0;
  int cmp_count = 0;
  int n_end = 0;
  int n_resync = 0;
  logic [7:0] rx_q[$];
  logic [31:0] rd;
  logic err;
  logic [7:0] eofs[3] = '{8'h89, 8'h39, 8'hE8};
  always #12.5 REF_CLK = ~REF_CLK;
  crd_rx_deframer dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .DEMOD_BIT_VALID(DEMOD_BIT_VALID), .DEMOD_BIT(DEMOD_BIT),
    .DEMOD_COLL(DEMOD_COLL), .DEMOD_RESYNC(DEMOD_RESYNC), .COPRO_DATA(COPRO_DATA),
    .COPRO_VALID(COPRO_VALID), .FRAME_END(FRAME_END), .IRQ(IRQ));
  crd_demod_model demod (.REF_CLK(REF_CLK), .DEMOD_BIT_VALID(DEMOD_BIT_VALID),
    .DEMOD_BIT(DEMOD_BIT), .DEMOD_COLL(DEMOD_COLL));
  always @(posedge REF_CLK) begin
    if (COPRO_VALID === 1'b1) rx_q.push_back(COPRO_DATA);
    if (FRAME_END === 1'b1) n_end++;
    if (DEMOD_RESYNC === 1'b1) n_resync++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Holds the request until ready is sampled high; no latency assumed
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h0, wd};
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {2'h0, idx, 2'h0}, d);
  endtask : wr
  task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, {2'h0, idx, 2'h0}, 8'h00);
    check(rd, {24'h0, exp});
  endtask : rd_chk
  task begin_rx(input logic [7:0] f, input logic [7:0] s, input logic [7:0] e,
                input logic [7:0] c);
    wr(`CRD_IDX_BIT_FRAMING, f);
    wr(`CRD_IDX_SYNC_MODE, s);
    wr(`CRD_IDX_EOF_PATTERN, e);
    wr(`CRD_IDX_IRQ_STATUS, 8'h0F);
    // Parity enable must already stand when the start write snapshots it
    wr(`CRD_IDX_CONTROL, c & 8'hFC);
    rx_q.delete();
    n_end = 0;
    n_resync = 0;
    wr(`CRD_IDX_CONTROL, c);
  endtask : begin_rx
  task run_end(input logic [7:0] mask, input logic [7:0] exp);
    int k;
    k = 0;
    while (n_end == 0 && k < 200) begin
      @(posedge REF_CLK);
      k++;
    end
    repeat (4) @(posedge REF_CLK);
    check(n_end, 1);
    apb(1'b0, {2'h0, `CRD_IDX_IRQ_STATUS, 2'h0}, 8'h00);
    check(rd & {24'h0, mask}, {24'h0, exp});
  endtask : run_end
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge REF_CLK);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    for (int i = 0; i < 4; i++) rd_chk(8'h58 + 8'(i), 8'h00);
    rd_chk(`CRD_IDX_CONTROL, 8'h04);
    wr(`CRD_IDX_BIT_FRAMING, 8'hFF);
    rd_chk(`CRD_IDX_BIT_FRAMING, 8'h3E);
    wr(`CRD_IDX_START_HIGH, 8'hC3);
    rd_chk(`CRD_IDX_START_HIGH, 8'hC3);
    apb(1'b0, 12'h1C0, 8'h00);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b0, 12'h161, 8'h00);
    check({31'h0, err}, 32'h1);
    // Noise ahead of a 4-bit start pattern, then a mid-frame config change
    wr(`CRD_IDX_START_LOW, 8'h0A);
    begin_rx(8'h00, 8'h40, 8'h00, 8'h01);
    for (int i = 5; i >= 0; i--) demod.send_sym(i == 3 || i == 1 ? 2'h2 : 2'h1);
    wr(`CRD_IDX_BIT_FRAMING, 8'h08);
    demod.send_char(8'hA5, 1'b0, 2'h0, 2'h0);
    repeat (4) @(posedge REF_CLK);
    check(rx_q.size(), 1);
    check({24'h0, rx_q[0]}, 32'hA5);
    rd_chk(`CRD_IDX_STATUS, 8'h01);
    wr(`CRD_IDX_CONTROL, 8'h02);
    run_end(8'h00, 8'h00);
    rd_chk(`CRD_IDX_STATUS, 8'h00);
    // Length taken from first byte, MSB first, odd parity, stop bits, slow bits
    demod.slow = 1'b1;
    begin_rx(8'h1E, 8'h00, 8'h00, 8'h05);
    demod.send_char(8'h02, 1'b1, ~^8'h02 ? 2'h2 : 2'h1, 2'h2);
    demod.send_char(8'h3C, 1'b1, ~^8'h3C ? 2'h2 : 2'h1, 2'h2);
    run_end(8'h0F, 8'h09);
    demod.slow = 1'b0;
    check(rx_q.size(), 2);
    check({24'h0, rx_q[0]}, 32'h02);
    check({24'h0, rx_q[1]}, 32'h3C);
    check(n_resync, 2);
    rd_chk(`CRD_IDX_BYTE_COUNT, 8'h02);
    rd_chk(`CRD_IDX_RX_DATA, 8'h3C);
    demod.send_char(8'h77, 1'b1, 2'h0, 2'h0);
    repeat (4) @(posedge REF_CLK);
    check(rx_q.size(), 2);
    check({31'h0, IRQ}, 32'h1 & 32'h0);
    wr(`CRD_IDX_IRQ_MASK, 8'h01);
    repeat (4) @(posedge REF_CLK);
    check({31'h0, IRQ}, 32'h1);
    wr(`CRD_IDX_IRQ_STATUS, 8'h0F);
    repeat (4) @(posedge REF_CLK);
    check({31'h0, IRQ}, 32'h0);
    wr(`CRD_IDX_IRQ_MASK, 8'h00);
    // Wrong stop bit aborts with a frame error
    begin_rx(8'h04, 8'h00, 8'h00, 8'h01);
    demod.send_char(8'h55, 1'b0, 2'h0, 2'h1);
    run_end(8'h02, 8'h02);
    check(rx_q.size(), 0);
    check(n_resync, 0);
    // Inverted even parity halts reception
    begin_rx(8'h20, 8'h00, 8'h00, 8'h05);
    demod.send_char(8'h01, 1'b0, 2'h1, 2'h0);
    run_end(8'h04, 8'h04);
    // End-of-frame symbols: leftmost active tuple is sent first
    foreach (eofs[j]) begin
      int n;
      n = 0;
      while (n < 4 && eofs[j][2 * n +: 2] != 2'h0) n++;
      begin_rx(8'h00, 8'h00, eofs[j], 8'h01);
      demod.send_char(8'hF0, 1'b0, 2'h0, 2'h0);
      for (int i = n - 1; i >= 0; i--) demod.send_sym(eofs[j][2 * i +: 2]);
      if (n == 0) begin
        demod.send_sym(2'h2);
        demod.send_sym(2'h1);
        repeat (20) @(posedge REF_CLK);
        check(n_end, 0);
        wr(`CRD_IDX_CONTROL, 8'h02);
      end
      run_end(8'h00, 8'h00);
      check({24'h0, rx_q[0]}, 32'hF0);
    end
    tally_and_finish();
  end
endmodule : crd_rx_deframer_test
bind crd_rx_deframer crd_rx_deframer_asserts chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DEMOD_BIT_VALID(DEMOD_BIT_VALID),
  .DEMOD_BIT(DEMOD_BIT), .DEMOD_COLL(DEMOD_COLL), .DEMOD_RESYNC(DEMOD_RESYNC),
  .COPRO_DATA(COPRO_DATA), .COPRO_VALID(COPRO_VALID), .FRAME_END(FRAME_END), .IRQ(IRQ));
